// ==== src/fspc_pkg.sv ====
// Purpose: shared constants and types of the flash self-program control
// Assumes: 100 MHz core clock, 16-bit program pointer, 32-word pages
// Notes:   one control register on the core's I/O port
package fspc_pkg;
    localparam logic [5:0] CTRL_ADDR    = 6'h37;
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam int         B_IRQEN      = 7;
    localparam int         B_CRBUSY     = 6;
    localparam int         B_RES        = 5;
    localparam int         B_CRENA      = 4;
    localparam int         B_LFSEL      = 3;
    localparam int         B_PGWR       = 2;
    localparam int         B_PGER       = 1;
    localparam int         B_SPEN       = 0;
    localparam logic [4:0] PAT_CRENA    = 5'h11;
    localparam logic [4:0] PAT_LFSEL    = 5'h09;
    localparam logic [4:0] PAT_PGWR     = 5'h05;
    localparam logic [4:0] PAT_PGER     = 5'h03;
    localparam logic [4:0] PAT_FILL     = 5'h01;
    localparam logic [2:0] STORE_WIN    = 3'h4;
    localparam logic [2:0] LOAD_WIN     = 3'h3;
    localparam logic [1:0] SEL_FUSE_LO  = 2'h0;
    localparam logic [1:0] SEL_LOCK     = 2'h1;
    localparam logic [1:0] SEL_FUSE_EXT = 2'h2;
    localparam logic [1:0] SEL_FUSE_HI  = 2'h3;
    localparam int         WORD_IDX_W   = 5;
    localparam int         PAGE_WORDS   = 32;
    localparam int         PAGE_W       = 10;
    localparam logic [15:0] NOCR_START  = 16'h1800;
    localparam int         CLK_NS       = 10;
    localparam int         PROG_MIN_NS  = 3700000;
    localparam int         PROG_MAX_NS  = 4500000;
    localparam int         PROG_CYC     = (PROG_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int         TMR_W        = 20;

    typedef enum logic [1:0] {OP_NONE, OP_ERASE, OP_WRITE, OP_LOCK} fspc_op_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } fspc_io_t;

    typedef struct packed {
        logic [7:0] lock;
        logic [7:0] lo;
        logic [7:0] hi;
        logic [7:0] ext;
    } fspc_fuse_t;

    typedef struct packed {
        logic              start;
        fspc_op_t          kind;
        logic [PAGE_W-1:0] page;
    } fspc_flash_t;
endpackage : fspc_pkg

// ==== src/fspc_page_buffer.sv ====
// Purpose: temporary page buffer, one 16-bit word per flip-flop row
// Assumes: write and clear never collide with the flash read side
// Notes:   loaded flag tells the controller that filling has begun
`timescale 1ns/10ps
`default_nettype none
module fspc_page_buffer
    import fspc_pkg::*;
(
    input  wire logic                  clock,    // core clock
    input  wire logic                  rst,      // sync reset, high
    input  wire logic                  wrEn,     // store one word
    input  wire logic [WORD_IDX_W-1:0] wrIdx,    // word index
    input  wire logic [15:0]           wrData,   // word value
    input  wire logic                  clr,      // wipe whole buffer
    input  wire logic [WORD_IDX_W-1:0] rdIdx,    // flash side index
    output logic      [15:0]           rdData,   // registered word
    output logic                       loaded    // filling in progress
);
    logic [15:0] mem_q [PAGE_WORDS];
    logic        loaded_q;

    // erased flash reads all ones, so the wiped buffer does too
    always_ff @(posedge clock)
    begin
        for (int i = 0; i < PAGE_WORDS; i++)
        begin
            if (rst || clr)
                mem_q[i] <= 16'hFFFF;
            else if (wrEn && wrIdx == i[WORD_IDX_W-1:0])
                mem_q[i] <= wrData;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst || clr)
            loaded_q <= 1'b0;
        else if (wrEn)
            loaded_q <= 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            rdData <= 16'h0000;
        else
            rdData <= mem_q[rdIdx];
    end

    assign loaded = loaded_q;
endmodule : fspc_page_buffer
`default_nettype wire

// ==== src/fspc_flash_self_program_control.sv ====
// Purpose: self-programming controller for on-chip program flash
// Assumes: core-clock inputs; fuse inputs are high when programmed
// Notes:   programming time counted in core cycles (PROG_CYC)
// Functional notes
// RQ1: ready interrupt requested while enabled, global on, and enable clear.
// RQ2: no ready interrupt during eeprom write or store operation.
// RQ3: without concurrent read, busy bit reads zero, writes ignored.
// RQ4: with concurrent read, busy bit is one while section blocked.
// RQ5: bit 5 reserved, always reads zero.
// RQ6: writing section-enable during buffer fill wipes the buffer.
// RQ7: lock/fuse select plus enable lets a load in three cycles read them.
// RQ8: page write armed; next store in four cycles writes buffer to page.
// RQ9: page write bit clears at finish or after unused window.
// RQ10: page erase armed; next store in four cycles erases the page.
// RQ11: page erase bit clears at finish or after unused window.
// RQ12: without concurrent read, core halted for whole erase or write.
// RQ13: enable permits a store only in the next four cycles.
// RQ14: plain enable store puts data pair in buffer word, pointer lsb ignored.
// RQ15: enable clears after store or idle window, holds during erase/write.
// RQ16: only five listed low-bit patterns act; others have no effect.
// RQ17: store starts programming only from the boot section.
// RQ18: store from boot section reaches every flash address.
// RQ19: programming concurrent section keeps core running.
// RQ20: programming non-concurrent section halts core for whole operation.
// RQ21: software avoids reading concurrent section while programming it.
// RQ22: software waits for earlier store and eeprom write before arming.
// RQ23: eeprom write blocks programming and lock/fuse reads.
// RQ24: pointer 1 lock, 0 fuse low, 3 fuse high, 2 extended fuse.
// RQ25: programmed bits read zero, unprogrammed read one.
// RQ26: each erase, write or lock write takes 3.7 ms to 4.5 ms.
// RQ27: arming window counted from cycle after the register write.
`timescale 1ns/10ps
`default_nettype none
module fspc_flash_self_program_control
    import fspc_pkg::*;
#(
    parameter bit HAS_CONC_READ = 1'b1,
    parameter int PROG_CYCLES   = PROG_CYC
)
(
    input  wire logic                  clock,       // core clock
    input  wire logic                  rst,         // sync reset, high
    input  wire fspc_pkg::fspc_io_t    ioBus,       // core i/o access
    output logic      [7:0]            regRdata,    // read data, next cycle
    input  wire logic                  storeExec,   // store instr pulse
    input  wire logic                  loadExec,    // load instr pulse
    input  wire logic [15:0]           ptr,         // flash byte pointer
    input  wire logic [15:0]           dataPair,    // store data pair
    input  wire logic                  fromBoot,    // executing in boot
    input  wire logic                  globalIrqEn, // core irq enable
    input  wire logic                  eepromWriteBusy, // eeprom busy
    input  wire fspc_pkg::fspc_fuse_t  fuses,       // programmed flags
    output logic      [7:0]            loadData,    // lock/fuse value
    output logic                       loadHit,     // loadData valid
    output logic                       storeReadyIrq, // irq request
    output logic                       cpuHalt,     // stall core
    output fspc_pkg::fspc_flash_t      flashOp,     // flash array command
    input  wire logic [WORD_IDX_W-1:0] bufRdIdx,    // flash buffer index
    output logic      [15:0]           bufRdData    // buffer word
);
    import fspc_pkg::*;

    logic             irqEn_q;
    logic             crBusy_q;
    logic             crEna_q;
    logic             lfSel_q;
    logic             pgWr_q;
    logic             pgEr_q;
    logic             spEn_q;
    logic [2:0]       win_q;
    logic [TMR_W-1:0] tmr_q;
    fspc_op_t         op_q;
    logic             halt_q;
    logic [7:0]       rd_q;
    logic [7:0]       ld_q;
    logic             hit_q;
    logic             irq_q;
    fspc_flash_t      fop_q;
    logic             bufLoaded;

    function automatic logic allowedPat(input logic [4:0] p);
        return p == PAT_CRENA || p == PAT_LFSEL || p == PAT_PGWR
            || p == PAT_PGER || p == PAT_FILL;
    endfunction : allowedPat

    function automatic logic [7:0] fuseSel(input fspc_fuse_t f,
                                           input logic [1:0] s);
        case (s)
            SEL_LOCK:     return ~f.lock;
            SEL_FUSE_LO:  return ~f.lo;
            SEL_FUSE_HI:  return ~f.hi;
            default:      return ~f.ext;
        endcase
    endfunction : fuseSel

    wire        opBusy   = op_q != OP_NONE;
    wire        ctrlSel  = ioBus.addr == CTRL_ADDR;
    wire        ctrlWr   = ioBus.wr && ctrlSel;
    wire [4:0]  wrPat    = ioBus.wdata[4:0];
    // arming refused while busy or eeprom writes; irq enable always lands
    wire        armOk    = ctrlWr && allowedPat(wrPat) && !opBusy //RQ16
                         && !spEn_q && !eepromWriteBusy;          //RQ23
    wire        inWin    = spEn_q && win_q != 3'h0;               //RQ13
    wire        loadWin  = win_q > (STORE_WIN - LOAD_WIN);
    wire        storeOk  = storeExec && inWin && fromBoot         //RQ17
                         && !eepromWriteBusy && !opBusy;
    wire        doErase  = storeOk && pgEr_q;                     //RQ10
    wire        doWrite  = storeOk && pgWr_q;                     //RQ8
    wire        doLock   = storeOk && lfSel_q;
    wire        doReen   = storeOk && crEna_q;
    wire        doFill   = storeOk && !pgEr_q && !pgWr_q
                         && !lfSel_q && !crEna_q;                 //RQ14
    wire        doPage   = doErase || doWrite;
    wire        doLoad   = loadExec && lfSel_q && loadWin && spEn_q
                         && !eepromWriteBusy;                     //RQ7
    wire        inNoConc = ptr >= NOCR_START;
    wire        needHalt = !HAS_CONC_READ || inNoConc || doLock;  //RQ12
    wire        tmrDone  = opBusy && tmr_q == TMR_W'(PROG_CYCLES - 1);
    wire        winEnd   = inWin && win_q == 3'h1 && !storeOk;
    wire        cmdEnd   = tmrDone || winEnd || doFill || doReen
                         || doLoad;
    wire        clrBuf   = armOk && wrPat == PAT_CRENA && bufLoaded;
    wire        irqNext  = irqEn_q && globalIrqEn && !spEn_q      //RQ1
                         && !eepromWriteBusy && !opBusy;          //RQ2
    wire [7:0]  ctrlVal  = {irqEn_q, crBusy_q && HAS_CONC_READ,   //RQ3
                            1'b0, crEna_q, lfSel_q, pgWr_q,       //RQ5
                            pgEr_q, spEn_q};

    fspc_page_buffer u_buf (
        .clock  (clock),
        .rst    (rst),
        .wrEn   (doFill),
        .wrIdx  (ptr[WORD_IDX_W:1]),                              //RQ14
        .wrData (dataPair),
        .clr    (clrBuf),                                         //RQ6
        .rdIdx  (bufRdIdx),
        .rdData (bufRdData),
        .loaded (bufLoaded)
    );

    // control bits: set by a legal write, dropped when the command ends; irq enable loaded by every write
    always_ff @(posedge clock)
    begin
        if (rst)
            {irqEn_q, crEna_q, lfSel_q, pgWr_q, pgEr_q, spEn_q}
                <= 6'h00;
        else if (armOk)
            {crEna_q, lfSel_q, pgWr_q, pgEr_q, spEn_q}
                <= wrPat;                                         //RQ13
        else if (cmdEnd && !(doPage || doLock))
            {crEna_q, lfSel_q, pgWr_q, pgEr_q, spEn_q}
                <= 5'h00;                                         //RQ9 RQ11 RQ15
        if (!rst && ctrlWr)
            irqEn_q <= ioBus.wdata[B_IRQEN];
    end

    // window starts the cycle after the write
    always_ff @(posedge clock)
    begin
        if (rst)
            win_q <= 3'h0;
        else if (armOk)
            win_q <= STORE_WIN;                                   //RQ27
        else if (storeOk || doLoad)
            win_q <= 3'h0;
        else if (win_q != 3'h0)
            win_q <= win_q - 3'h1;
    end

    // one timer shared by every long flash operation
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            op_q  <= OP_NONE;
            tmr_q <= '0;
        end
        else if (doPage || doLock)
        begin
            op_q  <= doErase ? OP_ERASE : doWrite ? OP_WRITE : OP_LOCK;
            tmr_q <= '0;
        end
        else if (tmrDone)
            op_q  <= OP_NONE;                                     //RQ26
        else if (opBusy)
            tmr_q <= tmr_q + TMR_W'(1);
    end

    // concurrent section busy: set by its programming, cleared by re-enable
    always_ff @(posedge clock)
    begin
        if (rst || !HAS_CONC_READ)
            crBusy_q <= 1'b0;                                     //RQ3
        else if (doPage && !inNoConc)
            crBusy_q <= 1'b1;                                     //RQ4
        else if (doReen)
            crBusy_q <= 1'b0;
    end

    // halt raised with the start, held until the timer ends
    always_ff @(posedge clock)
    begin
        if (rst)
            halt_q <= 1'b0;
        else if ((doPage || doLock) && needHalt)
            halt_q <= 1'b1;                                       //RQ20
        else if (tmrDone)
            halt_q <= 1'b0;                                       //RQ19
    end

    // pointer bits 15:6 go to the array as the page, boot section included
    always_ff @(posedge clock)
    begin
        if (rst)
            fop_q <= '0;
        else
        begin
            fop_q.start <= doPage || doLock;
            if (doPage || doLock)
            begin
                fop_q.kind <= doErase ? OP_ERASE
                            : doWrite ? OP_WRITE : OP_LOCK;
                fop_q.page <= ptr[15:16-PAGE_W];                  //RQ18
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rd_q  <= 8'h00;
            ld_q  <= 8'h00;
            hit_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            rd_q  <= (ioBus.rd && ctrlSel) ? ctrlVal : 8'h00;
            hit_q <= doLoad;
            if (doLoad)
                ld_q <= fuseSel(fuses, ptr[1:0]);                 //RQ24 RQ25
            irq_q <= irqNext;
        end
    end

    assign regRdata      = rd_q;
    assign loadData      = ld_q;
    assign loadHit       = hit_q;
    assign storeReadyIrq = irq_q;
    assign cpuHalt       = halt_q;
    assign flashOp       = fop_q;

    AST_IRQ_ON: assert property (@(posedge clock) disable iff (rst)
        irqNext |=> storeReadyIrq)                                //RQ1
        else $error("ready irq missing");
    AST_IRQ_OFF: assert property (@(posedge clock) disable iff (rst)
        (eepromWriteBusy || opBusy) |=> !storeReadyIrq)           //RQ2
        else $error("ready irq during busy");
    AST_RES_ZERO: assert property (@(posedge clock) disable iff (rst)
        regRdata[B_RES] == 1'b0)                                  //RQ5
        else $error("reserved bit set");
    AST_NOCONC_ZERO: assert property (@(posedge clock) disable iff (rst)
        !HAS_CONC_READ |-> !regRdata[B_CRBUSY])                   //RQ3
        else $error("busy bit without concurrent read");
    AST_WIN_EXPIRE: assert property (@(posedge clock) disable iff (rst)
        armOk ##1 (!storeExec && !loadExec)[*4] |=> !spEn_q)      //RQ15
        else $error("enable outlived window");
    AST_HOLD_EN: assert property (@(posedge clock) disable iff (rst)
        opBusy && op_q != OP_LOCK |-> spEn_q)                     //RQ15
        else $error("enable dropped during operation");
    AST_HALT: assert property (@(posedge clock) disable iff (rst)
        (doPage && needHalt) |=> cpuHalt throughout opBusy[*3])   //RQ12
        else $error("core not halted");
    AST_EE_BLOCK: assert property (@(posedge clock) disable iff (rst)
        eepromWriteBusy |=> !flashOp.start && !loadHit)           //RQ23
        else $error("eeprom write did not block");
    AST_LOCK_READ: assert property (@(posedge clock) disable iff (rst)
        doLoad && ptr[1:0] == SEL_LOCK
        |=> loadHit && loadData == ~$past(fuses.lock))            //RQ24
        else $error("lock bits read wrong");
    AST_APP_REFUSED: assert property (@(posedge clock) disable iff (rst)
        storeExec && !fromBoot |=> !flashOp.start)                //RQ17
        else $error("store from application started");

    COV_ERASE: cover property (@(posedge clock) doErase);
    COV_FILL_CLR: cover property (@(posedge clock) clrBuf);
    COV_DONE: cover property (@(posedge clock) tmrDone);
    COV_LOAD: cover property (@(posedge clock) doLoad);
endmodule : fspc_flash_self_program_control
`default_nettype wire

// ==== verification/fspc_cpu_model.sv ====
// Purpose: core model issuing control writes, reads, store and load instrs
// Assumes: each request launched by nba on a rising edge
// Notes:   callers wait fixed cycle counts before arming again
`timescale 1ns/10ps
`default_nettype none
module fspc_cpu_model
    import fspc_pkg::*;
(
    input  wire logic          clock,     // core clock
    output fspc_pkg::fspc_io_t ioBus,     // i/o access
    output logic               storeExec, // store pulse
    output logic               loadExec,  // load pulse
    output logic [15:0]        ptr,       // flash pointer
    output logic [15:0]        dataPair,  // store data
    output logic               fromBoot,  // running in boot section
    input  wire logic [7:0]    regRdata   // control read data
);
    initial
    begin
        ioBus     = '0;
        storeExec = 1'b0;
        loadExec  = 1'b0;
        ptr       = 16'h0000;
        dataPair  = 16'h0000;
        fromBoot  = 1'b1;
    end

    // released data shows the inverse, never the stale value
    task automatic wr(input logic [7:0] d);
        @(posedge clock);
        ioBus <= '{wr: 1'b1, rd: 1'b0, addr: CTRL_ADDR, wdata: d};
        @(posedge clock);
        ioBus.wr    <= 1'b0;
        ioBus.wdata <= ~d;
    endtask : wr

    task automatic rd(output logic [7:0] v);
        @(posedge clock);
        ioBus <= '{wr: 1'b0, rd: 1'b1, addr: CTRL_ADDR, wdata: 8'h00};
        @(posedge clock);
        ioBus.rd <= 1'b0;
        @(negedge clock);
        v = regRdata;
    endtask : rd

    task automatic st(input logic [15:0] p, input logic [15:0] d,
                      input logic b);
        @(posedge clock);
        ptr       <= p;
        dataPair  <= d;
        fromBoot  <= b;
        storeExec <= 1'b1;
        @(posedge clock);
        storeExec <= 1'b0;
        dataPair  <= ~d;
    endtask : st

    task automatic ld(input logic [15:0] p);
        @(posedge clock);
        ptr      <= p;
        loadExec <= 1'b1;
        @(posedge clock);
        loadExec <= 1'b0;
    endtask : ld
endmodule : fspc_cpu_model
`default_nettype wire

// ==== verification/testbench.sv ====
// Purpose: self-checking bench of the flash self-program controller
// Assumes: program time shortened to PCYC cycles
// Notes:   monitor counts flash starts and load hits
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import fspc_pkg::*;
    localparam int PCYC = 20;
    logic clock, rst, globalIrqEn, eepromWriteBusy, storeExec, loadExec;
    logic fromBoot, loadHit, storeReadyIrq, cpuHalt, ncHalt;
    logic [15:0] ptr, dataPair, bufRdData;
    logic [7:0]  regRdata, loadData, v, ncRdata;
    logic [4:0]  bufRdIdx;
    fspc_io_t    ioBus;
    fspc_fuse_t  fuses;
    fspc_flash_t flashOp, lastOp;
    int failures, total_checks, starts, hits, n;

    fspc_flash_self_program_control #(.PROG_CYCLES(PCYC)) dut (.clock, .rst,
        .ioBus, .regRdata, .storeExec, .loadExec, .ptr, .dataPair, .fromBoot,
        .globalIrqEn, .eepromWriteBusy, .fuses, .loadData, .loadHit,
        .storeReadyIrq, .cpuHalt, .flashOp, .bufRdIdx, .bufRdData);
    fspc_cpu_model cpu (.clock, .ioBus, .storeExec, .loadExec, .ptr,
        .dataPair, .fromBoot, .regRdata);
    // variant without concurrent read, fed the same stimulus
    fspc_flash_self_program_control #(.HAS_CONC_READ(1'b0),
        .PROG_CYCLES(PCYC)) dut_nc (.clock, .rst, .ioBus,
        .regRdata(ncRdata), .storeExec, .loadExec, .ptr, .dataPair,
        .fromBoot, .globalIrqEn, .eepromWriteBusy, .fuses, .loadData(),
        .loadHit(), .storeReadyIrq(), .cpuHalt(ncHalt), .flashOp(),
        .bufRdIdx, .bufRdData());

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock)
    begin
        if (flashOp.start === 1'b1)
        begin
            starts <= starts + 1;
            lastOp <= flashOp;
        end
        if (loadHit === 1'b1)
            hits <= hits + 1;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
        @(negedge clock);
    endtask : cyc

    task automatic close_out;
        if (failures == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    task automatic t_reg;
        cpu.rd(v);
        chk(v, 16'h0000);
        cpu.wr(8'hFF);
        cpu.rd(v);
        chk(v, 16'h0080);
        chk(storeReadyIrq, 1'b1);
        @(posedge clock);
        globalIrqEn <= 1'b0;
        cyc(2);
        chk(storeReadyIrq, 1'b0);
        @(posedge clock);
        globalIrqEn     <= 1'b1;
        eepromWriteBusy <= 1'b1;
        cyc(2);
        chk(storeReadyIrq, 1'b0);
        @(posedge clock);
        eepromWriteBusy <= 1'b0;
        cyc(2);
        chk(storeReadyIrq, 1'b1);
    endtask : t_reg

    task automatic t_fill;
        cpu.wr(8'h81);
        cpu.st(16'h0007, 16'h1234, 1'b1);
        @(posedge clock);
        bufRdIdx <= 5'h03;
        cyc(2);
        chk(bufRdData, 16'h1234);
        cpu.rd(v);
        chk(v, 16'h0080);
        cpu.wr(8'h91);
        cyc(6);
        chk(bufRdData, 16'hFFFF);
        cpu.rd(v);
        chk(v, 16'h0080);
    endtask : t_fill

    task automatic t_prog(input logic [7:0] c, input logic [15:0] p,
                          input fspc_op_t k, input logic h,
                          input logic [7:0] busy, input logic [7:0] done);
        n = starts;
        cpu.wr(c);
        cyc(2);
        cpu.st(p, 16'hA5A5, 1'b1);
        cyc(2);
        chk(starts - n, 1);
        chk({14'h0, lastOp.kind}, {14'h0, k});
        chk({6'h0, lastOp.page}, {6'h0, p[15:6]});
        chk(cpuHalt, h);
        chk(ncHalt, 1'b1);
        chk(storeReadyIrq, 1'b0);
        cpu.rd(v);
        chk(v, busy);
        chk(ncRdata, busy & 8'hBF);
        cyc(PCYC + 4);
        chk(cpuHalt, 1'b0);
        chk(ncHalt, 1'b0);
        cpu.rd(v);
        chk(v, done);
        chk(ncRdata, done & 8'hBF);
    endtask : t_prog

    task automatic t_refuse;
        for (int i = 0; i < 2; i++)
        begin
            n = starts;
            cpu.wr(i == 0 ? 8'h83 : 8'h85);
            cyc(3);
            cpu.st(16'h1800, 16'h0000, 1'b1);
            cyc(2);
            chk(starts - n, 0);
            cpu.rd(v);
            chk(v, 16'h0080);
        end
        cpu.wr(8'h83);
        cpu.st(16'h1800, 16'h0000, 1'b0);
        cyc(6);
        chk(starts - n, 0);
        chk(cpuHalt, 1'b0);
    endtask : t_refuse

    task automatic t_fuse;
        logic [7:0] ex [4];
        for (int j = 0; j < 2; j++)
        begin
            @(posedge clock);
            if (j == 1)
                fuses <= '{lock: 8'hFC, lo: 8'hA5, hi: 8'h7E, ext: 8'hF0};
            cyc(1);
            ex = '{~fuses.lo, ~fuses.lock, ~fuses.ext, ~fuses.hi};
            for (int i = 0; i < 4; i++)
            begin
                n = hits;
                cpu.wr(8'h89);
                cyc(1);
                cpu.ld(16'(i));
                cyc(1);
                chk(hits - n, 1);
                chk(loadData, ex[i]);
                cyc(3);
            end
        end
        @(posedge clock);
        eepromWriteBusy <= 1'b1;
        n = hits;
        cpu.wr(8'h89);
        cpu.ld(16'h0001);
        cyc(2);
        chk(hits - n, 0);
        cpu.rd(v);
        chk(v, 16'h0080);
        @(posedge clock);
        eepromWriteBusy <= 1'b0;
        // armed first, busy raised before the load
        n = hits;
        cpu.wr(8'h89);
        eepromWriteBusy <= 1'b1;
        cpu.ld(16'h0001);
        cyc(2);
        chk(hits - n, 0);
        @(posedge clock);
        eepromWriteBusy <= 1'b0;
        cyc(6);
    endtask : t_fuse

    task automatic t_reen;
        cpu.wr(8'h91);
        cpu.st(16'h0040, 16'h0000, 1'b1);
        cyc(2);
        cpu.rd(v);
        chk(v, 16'h0080);
        chk(ncRdata, 16'h0080);
    endtask : t_reen

    initial
    begin
        #50000;
        failures++;
        close_out();
    end

    initial
    begin
        rst             = 1'b1;
        globalIrqEn     = 1'b1;
        eepromWriteBusy = 1'b0;
        bufRdIdx        = 5'h00;
        fuses = '{lock: 8'h03, lo: 8'h5A, hi: 8'h81, ext: 8'h0F};
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        t_reg();
        t_fill();
        t_prog(8'h83, 16'h1800, OP_ERASE, 1'b1, 8'h83, 8'h80);
        t_prog(8'h85, 16'h0040, OP_WRITE, 1'b0, 8'hC5, 8'hC0);
        t_reen();
        t_prog(8'h89, 16'h0040, OP_LOCK, 1'b1, 8'h89, 8'h80);
        t_refuse();
        t_fuse();
        close_out();
    end
endmodule : testbench
`default_nettype wire
